/* File: logic/cpfsm_top.sv */
// Notes on behaviour
// - cell above overcharge threshold past overcharge delay releases the charge gate
// - overcharge delay is a fixed 100 ms interval
// - overcharge ends when the cell drops below the release level
// - overcharge also ends when cell is below threshold and a load is seen
// - above the overcharge threshold, load detection never ends overcharge
// - cell below overdischarge threshold past its delay turns discharge gate off
// - overdischarge delay defaults to 100 ms of continuous undervoltage
// - discharge resumes when cell is above the release level, but only once a charger has re-enabled the logic
// - in normal mode only, sustained sense overcurrent turns discharge gate off
// - two overcurrent levels, each with its own delay, higher level faster
// - lower level waits 10 ms, higher level waits 300 us
// - overcurrent ends and normal resumes once the pack terminals are open
// - in overcharge a load is seen when sense exceeds load-detect threshold
// - overdischarge powers down all delay and detection logic
// - in power-down the sense input is weakly pulled up to supply
// - a charger in power-down re-enables detection logic at once; delay channels stay gated off until overdischarge is left
// - after overdischarge, sense below charger threshold means charging
// - sense input serves current, charger or load detection by mode
// - during overdischarge the charge gate stays permitted
// - charge gate driven high in normal, released undriven in overcharge
// - discharge gate low in overdischarge or overcurrent, high otherwise
//
// The register offsets and the APB slave port are this design's own decisions.
module cpfsm_top #(
  parameter int OVERCHARGE_CYC_P   = cpfsm_pkg::OVERCHARGE_CYC,
  parameter int OVERDISCH_CYC_P    = cpfsm_pkg::OVERDISCH_CYC,
  parameter int OVERCUR_LOW_CYC_P  = cpfsm_pkg::OVERCUR_LOW_CYC,
  parameter int OVERCUR_HIGH_CYC_P = cpfsm_pkg::OVERCUR_HIGH_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [cpfsm_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          cell_above_overcharge_threshold,
  input  wire logic                          cell_below_overcharge_release_level,
  input  wire logic                          cell_below_overdischarge_threshold,
  input  wire logic                          cell_above_overdischarge_release_level,
  input  wire logic                          sense_above_overcurrent_threshold,
  input  wire logic                          sense_above_overcurrent_high,
  input  wire logic                          sense_above_load_detect_threshold,
  input  wire logic                          sense_below_charger_detect_threshold,
  input  wire logic                          pack_open,
  output logic                               charge_gate_out,
  output logic                               charge_gate_out_oe,
  output logic                               discharge_gate_out,
  output logic                               sense_pullup_en,
  output logic                               detect_en
);
  import cpfsm_pkg::*;
  default clocking chk_cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic [NUM_IN-1:0]  raw_in;
  logic [NUM_IN-1:0]  sync1_q;
  logic [NUM_IN-1:0]  sync2_q;
  cpfsm_state_t       state_q;
  cpfsm_state_t       state_d;
  logic               awake_q;
  logic [CNT_W-1:0]   dis_delay_q;
  logic [CNT_W-1:0]   cnt_q [NUM_CH];
  logic [CNT_W-1:0]   limit [NUM_CH];
  logic [NUM_CH-1:0]  cond;
  logic [NUM_CH-1:0]  hit;
  logic [31:0]        prdata_q;
  logic               setup;
  logic               access;
  logic               addr_ok;

  assign raw_in = {pack_open,
                   sense_below_charger_detect_threshold,
                   sense_above_load_detect_threshold,
                   sense_above_overcurrent_high,
                   sense_above_overcurrent_threshold,
                   cell_above_overdischarge_release_level,
                   cell_below_overdischarge_threshold,
                   cell_below_overcharge_release_level,
                   cell_above_overcharge_threshold};

  // two-flop synchroniser per comparator bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // delay channel conditions, all gated off while powered down
  always_comb begin
    cond            = '0;
    cond[CH_OVCHG]  = (state_q == ST_NORMAL) && sync2_q[IN_ABOVE_OCP];
    cond[CH_OVDIS]  = ((state_q == ST_NORMAL) || (state_q == ST_OVCHG) ||
                       (state_q == ST_OVCUR)) && sync2_q[IN_BELOW_ODP];
    cond[CH_OILO]   = (state_q == ST_NORMAL) && sync2_q[IN_OI_LOW];
    cond[CH_OIHI]   = (state_q == ST_NORMAL) && sync2_q[IN_OI_HIGH];
  end

  assign limit[CH_OVCHG] = CNT_W'(OVERCHARGE_CYC_P);
  assign limit[CH_OVDIS] = dis_delay_q;
  assign limit[CH_OILO]  = CNT_W'(OVERCUR_LOW_CYC_P);
  assign limit[CH_OIHI]  = CNT_W'(OVERCUR_HIGH_CYC_P);

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_delay
      assign hit[i] = cond[i] && (cnt_q[i] >= limit[i] - CNT_W'(1));
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          cnt_q[i] <= '0;
        end else if (!cond[i] || hit[i]) begin
          cnt_q[i] <= '0;
        end else begin
          cnt_q[i] <= cnt_q[i] + CNT_W'(1);
        end
      end
    end
  endgenerate

  // protection state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (hit[CH_OVDIS]) begin
          state_d = ST_OVDIS;
        end else if (hit[CH_OIHI] || hit[CH_OILO]) begin
          state_d = ST_OVCUR;
        end else if (hit[CH_OVCHG]) begin
          state_d = ST_OVCHG;
        end
      end
      ST_OVCHG: begin
        if (hit[CH_OVDIS]) begin
          state_d = ST_OVDIS;
        end else if (sync2_q[IN_BELOW_OCR]) begin
          state_d = ST_NORMAL;
        end else if (!sync2_q[IN_ABOVE_OCP] && sync2_q[IN_LOAD]) begin
          state_d = ST_NORMAL;
        end
      end
      ST_OVDIS: begin
        if (awake_q && sync2_q[IN_ABOVE_ODR]) begin
          state_d = ST_NORMAL;
        end
      end
      ST_OVCUR: begin
        if (hit[CH_OVDIS]) begin
          state_d = ST_OVDIS;
        end else if (sync2_q[IN_PACK_OPEN]) begin
          state_d = ST_NORMAL;
        end
      end
      default: state_d = ST_NORMAL;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // charger wake-up in power-down; cleared on the first clock after power-down is left
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awake_q <= 1'b0;
    end else if (state_q == ST_OVDIS && sync2_q[IN_CHARGER]) begin
      awake_q <= 1'b1;
    end else if (state_q != ST_OVDIS) begin
      awake_q <= 1'b0;
    end
  end

  assign charge_gate_out    = 1'b1;
  assign charge_gate_out_oe = (state_q != ST_OVCHG);
  assign discharge_gate_out = (state_q == ST_NORMAL) || (state_q == ST_OVCHG);
  assign sense_pullup_en    = (state_q == ST_OVDIS) && !awake_q;
  assign detect_en          = (state_q != ST_OVDIS) || awake_q;

  // apb slave, zero wait states
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign addr_ok = (paddr == REG_STATUS && !pwrite) || (paddr == REG_DIS_DELAY);
  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;
  assign prdata  = prdata_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_q <= '0;
    end else if (setup && !pwrite) begin
      case (paddr)
        REG_STATUS: begin
          prdata_q <= '0;
          prdata_q[3:0] <= state_q;
          prdata_q[ST_FLAGS_LSB +: 4] <= {detect_en, awake_q, discharge_gate_out,
                                          charge_gate_out_oe};
          prdata_q[ST_RAW_LSB +: NUM_IN] <= sync2_q;
        end
        REG_DIS_DELAY: prdata_q <= 32'(dis_delay_q);
        default:      prdata_q <= '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dis_delay_q <= CNT_W'(OVERDISCH_CYC_P);
    end else if (access && pwrite && paddr == REG_DIS_DELAY && pwdata[CNT_W-1:0] != '0) begin
      dis_delay_q <= pwdata[CNT_W-1:0];
    end
  end

  // checks: overcharge entry and release
  a_ovchg_entry: assert property (
    $rose(state_q == ST_OVCHG) |-> $past(cnt_q[CH_OVCHG]) == CNT_W'(OVERCHARGE_CYC_P - 1))
    else $error("overcharge entered without full delay");

  a_ovchg_no_early: assert property (
    (state_q == ST_NORMAL && !hit[CH_OVCHG] && !hit[CH_OVDIS] && !hit[CH_OILO] &&
     !hit[CH_OIHI]) |=> state_q == ST_NORMAL)
    else $error("state left normal without a qualified delay");

  a_ovchg_qualify: assert property (
    (state_q == ST_NORMAL && hit[CH_OVCHG] && !hit[CH_OVDIS] && !hit[CH_OILO] &&
     !hit[CH_OIHI]) |=> state_q == ST_OVCHG)
    else $error("overcharge not entered after its delay");

  a_ovchg_cnt_bound: assert property (
    cnt_q[CH_OVCHG] < limit[CH_OVCHG])
    else $error("overcharge counter ran past its limit");

  a_ovchg_release: assert property (
    (state_q == ST_OVCHG && sync2_q[IN_BELOW_OCR] && !hit[CH_OVDIS]) |=> state_q == ST_NORMAL)
    else $error("overcharge not released below release level");

  a_ovchg_load_exit: assert property (
    (state_q == ST_OVCHG && !sync2_q[IN_ABOVE_OCP] && sync2_q[IN_LOAD] && !hit[CH_OVDIS])
    |=> state_q == ST_NORMAL && charge_gate_out_oe)
    else $error("load did not release overcharge");

  a_ovchg_hold: assert property (
    (state_q == ST_OVCHG && sync2_q[IN_ABOVE_OCP] && !sync2_q[IN_BELOW_OCR] &&
     !hit[CH_OVDIS]) |=> state_q == ST_OVCHG)
    else $error("overcharge released while cell above threshold");

  a_ovchg_restart: assert property (
    !cond[CH_OVCHG] |=> cnt_q[CH_OVCHG] == '0)
    else $error("overcharge counter not restarted");

  // checks: overdischarge, power-down and wake
  a_ovdis_entry: assert property (
    $rose(state_q == ST_OVDIS) |-> $past(cnt_q[CH_OVDIS]) == $past(dis_delay_q) - CNT_W'(1))
    else $error("overdischarge entered without full delay");

  a_ovdis_enter: assert property (
    (state_q != ST_OVDIS && hit[CH_OVDIS]) |=> state_q == ST_OVDIS)
    else $error("overdischarge not entered after its delay");

  a_dis_delay_set: assert property (
    dis_delay_q != '0)
    else $error("overdischarge delay is zero");

  a_ovdis_restart: assert property (
    !cond[CH_OVDIS] |=> cnt_q[CH_OVDIS] == '0)
    else $error("overdischarge counter not restarted");

  a_ovdis_release: assert property (
    (state_q == ST_OVDIS && awake_q && sync2_q[IN_ABOVE_ODR]) |=> discharge_gate_out)
    else $error("discharge not re-enabled at once");

  a_pdown_stay: assert property (
    (state_q == ST_OVDIS && !awake_q) |=> state_q == ST_OVDIS)
    else $error("power-down left without a charger");

  a_pdown_idle: assert property (
    state_q == ST_OVDIS |-> cond == '0)
    else $error("delay channel running in power-down");

  a_pdown_cnt_clear: assert property (
    state_q == ST_OVDIS |=> cnt_q[CH_OVDIS] == '0)
    else $error("overdischarge counter running in power-down");

  a_pdown_outputs: assert property (
    (state_q == ST_OVDIS && !awake_q) |-> sense_pullup_en && !detect_en &&
    charge_gate_out_oe && !discharge_gate_out)
    else $error("power-down outputs wrong");

  a_pullup_pdown: assert property (
    sense_pullup_en |-> state_q == ST_OVDIS)
    else $error("sense pull-up on outside power-down");

  a_wake_charger: assert property (
    (state_q == ST_OVDIS && sync2_q[IN_CHARGER]) |=> detect_en && !sense_pullup_en)
    else $error("charger did not wake detection");

  a_wake_clear: assert property (
    state_q != ST_OVDIS |=> !awake_q)
    else $error("wake flag left set outside power-down");

  a_charger_awake: assert property (
    (state_q == ST_OVDIS && sync2_q[IN_CHARGER]) |=> awake_q)
    else $error("charger below threshold not taken as charging");

  a_sense_role: assert property (
    detect_en != sense_pullup_en)
    else $error("sense pin role ambiguous");

  // checks: overcurrent
  a_ocur_from_normal: assert property (
    $rose(state_q == ST_OVCUR) |-> $past(state_q) == ST_NORMAL &&
    ($past(hit[CH_OILO]) || $past(hit[CH_OIHI])))
    else $error("overcurrent entered outside normal mode");

  a_ocur_gated: assert property (
    state_q != ST_NORMAL |-> !cond[CH_OILO] && !cond[CH_OIHI] && !cond[CH_OVCHG])
    else $error("normal-only channel counting outside normal");

  a_ocur_high: assert property (
    (state_q == ST_NORMAL && hit[CH_OIHI] && !hit[CH_OVDIS]) |=> state_q == ST_OVCUR)
    else $error("high overcurrent not acted on");

  a_ocur_high_bound: assert property (
    cnt_q[CH_OIHI] < limit[CH_OIHI])
    else $error("high overcurrent counter ran past its limit");

  a_ocur_low: assert property (
    (state_q == ST_NORMAL && hit[CH_OILO] && !hit[CH_OVDIS]) |=> state_q == ST_OVCUR)
    else $error("low overcurrent not acted on");

  a_ocur_low_bound: assert property (
    cnt_q[CH_OILO] < limit[CH_OILO])
    else $error("low overcurrent counter ran past its limit");

  a_ocur_release: assert property (
    (state_q == ST_OVCUR && sync2_q[IN_PACK_OPEN] && !hit[CH_OVDIS]) |=> state_q == ST_NORMAL)
    else $error("overcurrent not released by open terminals");

  a_cnt_restart: assert property (
    !cond[CH_OIHI] |=> cnt_q[CH_OIHI] == '0)
    else $error("overcurrent counter not restarted");

  a_oilo_restart: assert property (
    !cond[CH_OILO] |=> cnt_q[CH_OILO] == '0)
    else $error("low overcurrent counter not restarted");

  // checks: gate outputs per state
  a_gate_normal: assert property (
    state_q == ST_NORMAL |-> charge_gate_out_oe && charge_gate_out && discharge_gate_out)
    else $error("gates not both on in normal mode");

  a_gate_ovchg: assert property (
    state_q == ST_OVCHG |-> !charge_gate_out_oe && discharge_gate_out)
    else $error("charge gate not released in overcharge");

  a_gate_ovcur: assert property (
    state_q == ST_OVCUR |-> !discharge_gate_out && charge_gate_out_oe)
    else $error("discharge gate not off in overcurrent");

  a_gate_ovdis: assert property (
    state_q == ST_OVDIS |-> charge_gate_out_oe && !discharge_gate_out)
    else $error("charge gate not permitted in overdischarge");

  c_overcharge_cycle: cover property (
    state_q == ST_OVCHG ##1 state_q == ST_NORMAL);
  c_overdis_wake: cover property (
    state_q == ST_OVDIS ##1 awake_q ##[1:20] state_q == ST_NORMAL);
  c_overcur_high: cover property (
    hit[CH_OIHI] ##1 state_q == ST_OVCUR);
  c_overcur_low: cover property (
    hit[CH_OILO] && !hit[CH_OIHI] ##1 state_q == ST_OVCUR);
  c_load_release: cover property (
    state_q == ST_OVCHG && sync2_q[IN_LOAD] ##1 state_q == ST_NORMAL);
endmodule

/* File: logic/cpfsm_pkg.sv */
package cpfsm_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS         = 10;
  localparam int OVERCHARGE_DELAY_US   = 100000;
  localparam int OVERDISCH_DELAY_US    = 100000;
  localparam int OVERCUR_LOW_DELAY_US  = 10000;
  localparam int OVERCUR_HIGH_DELAY_US = 300;
  localparam int OVERCHARGE_CYC   = OVERCHARGE_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int OVERDISCH_CYC    = OVERDISCH_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int OVERCUR_LOW_CYC  = OVERCUR_LOW_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int OVERCUR_HIGH_CYC = OVERCUR_HIGH_DELAY_US * 1000 / CLK_PERIOD_NS;

  localparam int CNT_W = 24;

  // delay channels
  localparam int NUM_CH   = 4;
  localparam int CH_OVCHG = 0;
  localparam int CH_OVDIS = 1;
  localparam int CH_OILO  = 2;
  localparam int CH_OIHI  = 3;

  // comparator inputs after synchronisation
  localparam int NUM_IN       = 9;
  localparam int IN_ABOVE_OCP = 0;
  localparam int IN_BELOW_OCR = 1;
  localparam int IN_BELOW_ODP = 2;
  localparam int IN_ABOVE_ODR = 3;
  localparam int IN_OI_LOW    = 4;
  localparam int IN_OI_HIGH   = 5;
  localparam int IN_LOAD      = 6;
  localparam int IN_CHARGER   = 7;
  localparam int IN_PACK_OPEN = 8;

  // apb register map
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  REG_STATUS      = 8'h00;
  localparam logic [7:0]  REG_DIS_DELAY   = 8'h04;
  localparam int          ST_FLAGS_LSB    = 4;
  localparam int          ST_RAW_LSB      = 8;

  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_OVCHG  = 4'h2,
    ST_OVDIS  = 4'h4,
    ST_OVCUR  = 4'h8
  } cpfsm_state_t;

endpackage

/* File: verification/cpfsm_pack_model.sv */
// cell, charger/load and the two external switches as seen by the comparators
module cpfsm_pack_model #(
  parameter int OCP_MV = 4300,
  parameter int HYS_MV = 200,
  parameter int ODP_MV = 2400,
  parameter int ODR_MV = 2900,
  parameter int OIP_MV = 200,
  parameter int OIH_MV = 1000,
  parameter int LD_MV  = 300,
  parameter int CH_MV  = -300
) (
  input  wire logic signed [15:0] cell_mv,
  input  wire logic signed [15:0] sense_mv,
  input  wire logic               load_off,
  input  wire logic               charge_gate_out,
  input  wire logic               charge_gate_out_oe,
  input  wire logic               discharge_gate_out,
  input  wire logic               sense_pullup_en,
  output logic                    above_ocp,
  output logic                    below_ocr,
  output logic                    below_odp,
  output logic                    above_odr,
  output logic                    oi_low,
  output logic                    oi_high,
  output logic                    load_seen,
  output logic                    charger_seen,
  output logic                    pack_open,
  output logic                    charge_fet_on,
  output logic                    discharge_fet_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [15:0] sense_eff;
  // weak pull-up lifts the sense pin to the cell unless a charger pulls it negative
  assign sense_eff = (sense_pullup_en && sense_mv > CH_MV) ? cell_mv : sense_mv;
  assign above_ocp = cell_mv > OCP_MV;
  assign below_ocr = cell_mv < OCP_MV - HYS_MV;
  assign below_odp = cell_mv < ODP_MV;
  assign above_odr = cell_mv > ODR_MV;
  assign oi_low = sense_eff > OIP_MV;
  assign oi_high = sense_eff > OIH_MV;
  assign load_seen = sense_eff > LD_MV;
  assign charger_seen = sense_eff < CH_MV;
  assign pack_open = load_off;
  // released gate is pulled low through the external resistor
  assign charge_fet_on = charge_gate_out_oe & charge_gate_out;
  assign discharge_fet_on = discharge_gate_out;
endmodule

/* File: verification/cell_protection_fsm_bench.sv */
module cell_protection_fsm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpfsm_pkg::*;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, load_off;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] cell_mv, sense_mv;
  logic a_ocp, b_ocr, b_odp, a_odr, oil, oih, ld, chg, popen, cg, cg_oe, dg, pu, den, cfet, dfet;
  logic err;
  int n_fail, n_checks;
  int cyc = 0;
  cpfsm_top #(.OVERCHARGE_CYC_P(20), .OVERDISCH_CYC_P(8), .OVERCUR_LOW_CYC_P(10),
    .OVERCUR_HIGH_CYC_P(4)) dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cell_above_overcharge_threshold(a_ocp),
    .cell_below_overcharge_release_level(b_ocr), .cell_below_overdischarge_threshold(b_odp),
    .cell_above_overdischarge_release_level(a_odr), .sense_above_overcurrent_threshold(oil),
    .sense_above_overcurrent_high(oih), .sense_above_load_detect_threshold(ld),
    .sense_below_charger_detect_threshold(chg), .pack_open(popen), .charge_gate_out(cg),
    .charge_gate_out_oe(cg_oe), .discharge_gate_out(dg), .sense_pullup_en(pu), .detect_en(den));
  cpfsm_pack_model model (.cell_mv(cell_mv), .sense_mv(sense_mv), .load_off(load_off),
    .charge_gate_out(cg), .charge_gate_out_oe(cg_oe), .discharge_gate_out(dg),
    .sense_pullup_en(pu), .above_ocp(a_ocp), .below_ocr(b_ocr), .below_odp(b_odp),
    .above_odr(a_odr), .oi_low(oil), .oi_high(oih), .load_seen(ld), .charger_seen(chg),
    .pack_open(popen), .charge_fet_on(cfet), .discharge_fet_on(dfet));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drive(input int c, input int s, input logic open);
    @(posedge clock);
    cell_mv <= 16'(c);
    sense_mv <= 16'(s);
    load_off <= open;
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    {psel, penable, pwrite, load_off} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cell_mv = 16'sd3700;
    sense_mv = 16'sd0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    at(4);
    chk(32'({cfet, dfet, den, pu}), 32'he);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0ab1);
    apb(1'b0, REG_DIS_DELAY, 32'h0);
    chk(rd, 32'h0000_0008);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, REG_STATUS, 32'h0000_00ff);
    chk(32'(err), 32'h1);
    // overcharge with an interrupted qualification
    drive(4400, 0, 1'b0);
    at(12);
    drive(4200, 0, 1'b0);
    at(5);
    drive(4400, 0, 1'b0);
    at(12);
    chk(32'(cfet), 32'h1);
    at(14);
    chk(32'({cfet, cg_oe}), 32'h0);
    drive(4400, 500, 1'b0);
    at(10);
    chk(32'(cfet), 32'h0);
    drive(4200, 500, 1'b0);
    at(5);
    chk(32'(cfet), 32'h1);
    drive(4400, 0, 1'b0);
    at(30);
    chk(32'(cfet), 32'h0);
    drive(4000, 0, 1'b0);
    at(5);
    chk(32'(cfet), 32'h1);
    // both overcurrent levels and release by open terminals
    drive(3700, 500, 1'b0);
    at(9);
    chk(32'(dfet), 32'h1);
    at(10);
    chk(32'(dfet), 32'h0);
    drive(3700, 0, 1'b1);
    at(6);
    chk(32'(dfet), 32'h1);
    drive(3700, 1500, 1'b0);
    at(9);
    chk(32'(dfet), 32'h0);
    drive(3700, 0, 1'b1);
    at(6);
    chk(32'(dfet), 32'h1);
    drive(3700, 0, 1'b0);
    // overdischarge with a programmed delay, power-down and charger wake
    apb(1'b1, REG_DIS_DELAY, 32'd30);
    apb(1'b1, REG_DIS_DELAY, 32'h0);
    apb(1'b0, REG_DIS_DELAY, 32'h0);
    chk(rd, 32'd30);
    drive(2300, 0, 1'b0);
    at(25);
    chk(32'(dfet), 32'h1);
    at(15);
    chk(32'({dfet, cfet, den, pu}), 32'h5);
    drive(3000, 0, 1'b0);
    at(10);
    chk(32'({dfet, den}), 32'h0);
    drive(3000, -500, 1'b0);
    at(4);
    chk(32'({den, dfet, cfet}), 32'h7);
    drive(3700, 0, 1'b0);
    at(4);
    complete_run();
  end
endmodule
